// File: tmf_card.sv
// Behavioural model of the removable card facing the tunnel control block.
// Assumes the bench drives on the falling clock edge; bytes land on the rising edge.
`timescale 1ns/1ps
module tmf_card
  import tmf_pkg::*;
(
  input  wire logic               clk_i,   // Block clock
  input  wire logic               stall_i, // Hold off forwarded bytes
  input  wire tmf_pkg::tmf_byte_t fwd_i,   // Bytes forwarded by the host
  output logic                    ready_o, // Taking forwarded bytes
  output tmf_pkg::tmf_byte_t      msg_o    // Message bytes to the host
);
  logic [7:0] rx_q[$];
  initial begin
    msg_o = '0;
    ready_o = 1'b0;
  end
  always @(negedge clk_i) ready_o <= !stall_i;
  always @(posedge clk_i) begin
    if (ready_o && fwd_i.valid) begin
      rx_q.push_back(fwd_i.data);
    end
  end
  // Mode select or tunnel list; one address
  task automatic send_select(input logic [7:0] mode, input logic [47:0] mac,
                             input logic [15:0] strip, input bit tun);
    logic [7:0] b[$];
    int i;
    b.push_back(8'h9F);
    b.push_back(8'h8E);
    b.push_back(8'h07);
    b.push_back(tun ? 8'h0A : 8'h01);
    b.push_back(mode);
    if (tun) begin
      b.push_back(8'h01);
      for (i = 0; i < 6; i++) b.push_back(mac[47-8*i -: 8]);
      b.push_back(strip[15:8]);
      b.push_back(strip[7:0]);
    end
    for (i = 0; i < b.size(); i++) begin
      @(negedge clk_i);
      msg_o.valid = 1'b1;
      msg_o.last = (i == b.size() - 1);
      msg_o.data = b[i];
    end
    @(negedge clk_i);
    msg_o = '0;
  endtask
endmodule

// File: tmf_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and an active low asynchronous reset.
`timescale 1ns/1ps
module tmf_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,     // Clock
  input  wire logic             rst_n_i,   // Reset, active low
  input  wire logic [WIDTH-1:0] in_data_i, // Write data
  input  wire logic             in_valid_i, // Write valid
  output logic                  in_ready_o, // Not full
  output logic [WIDTH-1:0]      out_data_o, // Read data
  output logic                  out_valid_o, // Not empty
  input  wire logic             out_ready_i  // Read ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  wire              do_wr = in_valid_i && in_ready_o;
  wire              do_rd = out_valid_o && out_ready_i;

  assign in_ready_o  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign out_data_o  = mem[rd_ptr_ff];

  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (do_wr) wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      if (do_rd) rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  a_fifo_no_overflow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    count_ff == (AW+1)'(DEPTH) |-> !do_wr || do_rd) else $error("FIFO overflow");
endmodule

// File: tmf_pkg.sv
// Package for the tunnel mode and filter control block.
// Assumes a single 20 MHz clock domain and byte-wide message streams.
package tmf_pkg;
  localparam logic [23:0] TAG_MODE_QUERY  = 24'h9F_8E06;
  localparam logic [23:0] TAG_MODE_SELECT = 24'h9F_8E07;
  localparam logic [7:0]  MODE_LEGACY     = 8'h00;
  localparam logic [7:0]  MODE_TUN2       = 8'h01;
  localparam logic [7:0]  MODE_TUN1       = 8'h02;
  localparam logic [7:0]  MODE_ADV2       = 8'h03;
  localparam logic [7:0]  MODE_ADV1       = 8'h04;
  localparam int          MAX_ADDR        = 8;
  localparam int          MAC_BYTES       = 6;
  localparam int          FIFO_DEPTH      = 4;
  localparam int          FIFO_WIDTH      = 9;
  localparam logic [15:0] STRIP_RESET     = 16'h0000;
  localparam logic [7:0]  QUERY_LEN       = 8'h00;
  localparam logic [1:0]  STAT_GRANT      = 2'h0;
  localparam logic [1:0]  STAT_TX_BUSY    = 2'h1;
  localparam logic [1:0]  STAT_OTHER      = 2'h2;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } tmf_byte_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] freq;
    logic [7:0]  rate;
    logic [7:0]  power;
  } tmf_tune_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] status;
  } tmf_reply_t;
endpackage

// File: tmf_top.sv
// Tunnel mode and tunnel filter control, host end.
// Assumes byte streams from the card and from the downstream, synchronous to ref_clk_i.
`timescale 1ns/1ps
module tmf_top
  import tmf_pkg::*;
(
  input  wire logic                ref_clk_i,        // 20 MHz clock
  input  wire logic                reset_n_i,        // Async reset, active low
  input  wire logic                query_start_i,    // Pulse: send mode query
  output tmf_pkg::tmf_byte_t       query_byte_o,     // Mode query byte stream
  input  wire tmf_pkg::tmf_byte_t  card_msg_i,       // Message bytes from card
  input  wire tmf_pkg::tmf_byte_t  pkt_i,            // Downstream packet bytes
  input  wire logic                flow_open_i,      // Extended channel flow open
  output logic                     pkt_ready_o,      // Downstream may send
  output tmf_pkg::tmf_byte_t       fwd_o,            // Bytes forwarded to card
  input  wire logic                fwd_ready_i,      // Card side ready
  input  wire tmf_pkg::tmf_tune_t  tx_tune_i,        // Return tune request
  input  wire tmf_pkg::tmf_tune_t  rx_tune_i,        // Forward tune request
  output tmf_pkg::tmf_reply_t      tx_reply_o,       // Return tune answer
  output tmf_pkg::tmf_reply_t      rx_reply_o,       // Forward tune answer
  output tmf_pkg::tmf_tune_t       tx_setting_o,     // Applied return tuning
  output logic [7:0]               mode_o,           // Current mode
  output logic                     return_tx_en_o,   // Legacy transmitter enable
  output logic                     modem_tx_en_o,    // Modem transmitter enable
  output logic                     fwd_rx_en_o,      // Forward receiver enable
  output logic                     scan_o,           // Descriptor scan active
  input  wire logic [7:0]          dcd_count_i,      // Descriptor change count
  input  wire logic                dcd_valid_i,      // Pulse: descriptor seen
  input  wire logic                modem_reset_i,    // Pulse: modem reset
  output logic                     dcd_relay_o,      // Pulse: relay descriptor
  input  wire logic                tunnel_error_i,   // Pulse: card says invalid
  output logic                     next_channel_o,   // Pulse: retune downstream
  output logic                     channel_valid_o,  // Listed MAC seen on channel
  input  wire logic                upstream_channel_ident_known_i,     // Pulse: upstream id known
  input  wire logic [7:0]          upstream_channel_ident_i,           // Upstream channel id
  input  wire logic [15:0]         owner_id_i,       // Host tunnel owner id
  output logic                     info_send_o,      // Pulse: send host info
  output logic [7:0]               info_upstream_channel_ident_o,      // Reported upstream id
  output logic [15:0]              info_owner_o      // Reported owner id
);
  typedef enum logic [2:0] {
    P_TAG0  = 3'b000, P_TAG1 = 3'b001, P_TAG2 = 3'b011, P_MODE = 3'b010,
    P_COUNT = 3'b110, P_MAC  = 3'b111, P_STR0 = 3'b101, P_STR1 = 3'b100
  } tmf_parse_t;

  function automatic logic is_tunnel(input logic [7:0] m);
    return (m >= MODE_TUN2) && (m <= MODE_ADV1);
  endfunction
  function automatic logic is_basic(input logic [7:0] m);
    return (m == MODE_TUN2) || (m == MODE_TUN1);
  endfunction

  // Reset synchroniser
  logic rst_meta_ff, rst_n;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  // Mode query transmitter
  logic [2:0] q_idx_ff;
  logic [2:0] nxt_q_idx;
  wire        q_busy = (q_idx_ff != 3'd0);
  wire [7:0]  q_byte = (q_idx_ff == 3'd1) ? TAG_MODE_QUERY[23:16] :
                       (q_idx_ff == 3'd2) ? TAG_MODE_QUERY[15:8] :
                       (q_idx_ff == 3'd3) ? TAG_MODE_QUERY[7:0] : QUERY_LEN;
  assign nxt_q_idx = q_busy ? ((q_idx_ff == 3'd4) ? 3'd0 : q_idx_ff + 3'd1) :
                     (query_start_i ? 3'd1 : 3'd0);
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q_idx_ff     <= 3'd0;
      query_byte_o <= '0;
    end else begin
      q_idx_ff     <= nxt_q_idx;
      query_byte_o <= '{valid: q_busy, last: (q_idx_ff == 3'd4), data: q_byte};
    end
  end

  // Mode select parser
  tmf_parse_t  st_ff, nxt_st;
  logic [7:0]  sel_mode_ff, cnt_ff, idx_ff;
  logic [2:0]  byte_ff;
  logic [47:0] mac_sh_ff;
  logic [47:0] stage_ff [MAX_ADDR];
  logic [47:0] mac_ff [MAX_ADDR];
  logic [7:0]  mac_n_ff;
  logic [15:0] strip_ff;
  logic [7:0]  strip_hi_ff;
  wire         cb = card_msg_i.valid;
  wire [7:0]   cd = card_msg_i.data;
  wire         mode_ok = (cd <= MODE_ADV1);
  wire         commit_plain = cb && (st_ff == P_MODE) && byte_ff[0] && mode_ok && !is_tunnel(cd);
  wire         commit_tun = cb && (st_ff == P_STR1);
  wire         mac_done = cb && (st_ff == P_MAC) && (byte_ff == 3'(MAC_BYTES - 1));

  always_comb begin
    nxt_st = st_ff;
    if (cb) begin
      case (st_ff)
        P_TAG0:  nxt_st = (cd == TAG_MODE_SELECT[23:16]) ? P_TAG1 : P_TAG0;
        P_TAG1:  nxt_st = (cd == TAG_MODE_SELECT[15:8]) ? P_TAG2 : P_TAG0;
        P_TAG2:  nxt_st = (cd == TAG_MODE_SELECT[7:0]) ? P_MODE : P_TAG0;
        // Length byte is skipped by staying in P_MODE for one byte while byte_ff is 0
        P_MODE:  nxt_st = (byte_ff == 3'd0) ? P_MODE :
                          (!mode_ok ? P_TAG0 : (is_tunnel(cd) ? P_COUNT : P_TAG0));
        P_COUNT: nxt_st = (cd == 8'h00) ? P_STR0 : P_MAC;
        P_MAC:   nxt_st = (mac_done && (idx_ff + 8'd1 == cnt_ff)) ? P_STR0 : P_MAC;
        P_STR0:  nxt_st = P_STR1;
        default: nxt_st = P_TAG0;
      endcase
      if (card_msg_i.last && st_ff != P_STR1) nxt_st = P_TAG0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_ff       <= P_TAG0;
      byte_ff     <= 3'd0;
      sel_mode_ff <= MODE_LEGACY;
      cnt_ff      <= 8'h00;
      idx_ff      <= 8'h00;
      mac_sh_ff   <= '0;
      strip_hi_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      if (cb) begin
        if (st_ff == P_MODE) begin
          byte_ff     <= (byte_ff == 3'd0) ? 3'd1 : 3'd0;
          sel_mode_ff <= cd;
        end
        if (st_ff == P_COUNT) begin
          cnt_ff <= (cd > 8'(MAX_ADDR)) ? 8'(MAX_ADDR) : cd;
          idx_ff <= 8'h00;
        end
        if (st_ff == P_MAC) begin
          mac_sh_ff <= {mac_sh_ff[39:0], cd};
          byte_ff   <= mac_done ? 3'd0 : byte_ff + 3'd1;
          if (mac_done) idx_ff <= idx_ff + 8'd1;
        end
        if (st_ff == P_STR0) strip_hi_ff <= cd;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (mac_done && idx_ff < 8'(MAX_ADDR)) stage_ff[idx_ff[2:0]] <= {mac_sh_ff[39:0], cd};
  end

  // Mode and filter list, committed only when a message completes
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_o   <= MODE_LEGACY;
      mac_n_ff <= 8'h00;
      strip_ff <= STRIP_RESET;
    end else if (commit_plain) begin
      mode_o   <= cd;
      mac_n_ff <= 8'h00;
    end else if (commit_tun) begin
      mode_o   <= sel_mode_ff;
      mac_n_ff <= cnt_ff;
      strip_ff <= {strip_hi_ff, cd};
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (commit_tun) mac_ff <= stage_ff;
  end

  // Transmitter and receiver enables
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      return_tx_en_o <= 1'b1;
      modem_tx_en_o  <= 1'b0;
      fwd_rx_en_o    <= 1'b1;
    end else begin
      return_tx_en_o <= (mode_o == MODE_LEGACY);
      modem_tx_en_o  <= (mode_o == MODE_TUN2) || (mode_o == MODE_ADV2);
      fwd_rx_en_o    <= !is_tunnel(mode_o);
    end
  end

  // Tune request handling
  wire [1:0] tx_stat = (mode_o == MODE_LEGACY) ? STAT_GRANT :
                       ((mode_o == MODE_TUN2) || (mode_o == MODE_ADV2)) ? STAT_TX_BUSY :
                       STAT_OTHER;
  wire [1:0] rx_stat = is_tunnel(mode_o) ? STAT_OTHER : STAT_GRANT;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_reply_o   <= '0;
      rx_reply_o   <= '0;
      tx_setting_o <= '0;
    end else begin
      tx_reply_o <= '{valid: tx_tune_i.valid, status: tx_stat};
      rx_reply_o <= '{valid: rx_tune_i.valid, status: rx_stat};
      if (tx_tune_i.valid && tx_stat == STAT_GRANT) begin
        tx_setting_o <= tx_tune_i;
      end else begin
        tx_setting_o.valid <= 1'b0;
      end
    end
  end

  // Packet filter: header capture, match, strip
  logic [2:0]  hdr_ff, rp_ff;
  logic [47:0] dst_ff, rp_buf_ff;
  logic        pass_ff;
  logic [15:0] pos_ff;
  wire         fifo_in_ready;
  wire         pb = pkt_i.valid && pkt_ready_o;
  wire [47:0]  dst_now = {dst_ff[39:0], pkt_i.data};
  logic        hit;
  always_comb begin
    hit = 1'b0;
    for (int i = 0; i < MAX_ADDR; i++) begin
      if (8'(i) < mac_n_ff && mac_ff[i] == dst_now) hit = 1'b1;
    end
  end
  wire filter_on = is_basic(mode_o) && flow_open_i;
  wire at_dst_end = pb && (hdr_ff == 3'(MAC_BYTES - 1));
  wire pass_now = at_dst_end ? (filter_on && hit) : pass_ff;
  wire keep = pass_now && (pos_ff >= strip_ff);
  wire rp_act = (rp_ff != 3'(MAC_BYTES));                             // Held header going out
  wire rp_start = at_dst_end && filter_on && hit && (strip_ff < 16'(MAC_BYTES));
  wire rp_push = rp_act && fifo_in_ready;
  wire [7:0] rp_byte = rp_buf_ff[47 - 8*rp_ff -: 8];
  wire push = pb && keep && !rp_start;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hdr_ff          <= 3'd0;
      dst_ff          <= '0;
      pass_ff         <= 1'b0;
      pos_ff          <= 16'h0000;
      rp_ff           <= 3'(MAC_BYTES);
      rp_buf_ff       <= '0;
      channel_valid_o <= 1'b0;
    end else begin
      if (pb) begin
        dst_ff    <= dst_now;
        hdr_ff    <= pkt_i.last ? 3'd0 : ((hdr_ff == 3'(MAC_BYTES)) ? hdr_ff : hdr_ff + 3'd1);
        pos_ff    <= pkt_i.last ? 16'h0000 : pos_ff + 16'h0001;
        pass_ff   <= pkt_i.last ? 1'b0 : pass_now;
      end
      if (rp_start) rp_ff <= strip_ff[2:0];
      else if (rp_push) rp_ff <= rp_ff + 3'd1;
      if (rp_start) rp_buf_ff <= dst_now;
      if (at_dst_end && hit && is_tunnel(mode_o)) channel_valid_o <= 1'b1;
      else if (next_channel_o || commit_tun) channel_valid_o <= 1'b0;
    end
  end
  wire [8:0] fifo_out;
  wire       fifo_valid;
  wire       out_take = fifo_valid && (!fwd_o.valid || fwd_ready_i);
  tmf_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) tmf_fifo_inst (
    .clk_i       (ref_clk_i),
    .rst_n_i     (rst_n),
    .in_data_i   (rp_act ? {1'b0, rp_byte} : {pkt_i.last, pkt_i.data}),
    .in_valid_i  (push || rp_push),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_valid),
    .out_ready_i (out_take)
  );

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fwd_o       <= '0;
      pkt_ready_o <= 1'b0;
    end else begin
      pkt_ready_o <= fifo_in_ready && !push && !rp_start && !rp_act;
      if (out_take) fwd_o <= '{valid: 1'b1, last: fifo_out[8], data: fifo_out[7:0]};
      else if (fwd_ready_i) fwd_o.valid <= 1'b0;
    end
  end

  // Advanced descriptor scanning and relay
  logic       seen_ff, force_ff;
  logic [7:0] last_cnt_ff;
  wire        adv = (mode_o == MODE_ADV2) || (mode_o == MODE_ADV1);
  wire        relay = scan_o && dcd_valid_i && !is_basic(mode_o) &&
                      (force_ff || modem_reset_i || !seen_ff || dcd_count_i != last_cnt_ff);
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scan_o         <= 1'b0;
      seen_ff        <= 1'b0;
      force_ff       <= 1'b0;
      last_cnt_ff    <= 8'h00;
      dcd_relay_o    <= 1'b0;
      next_channel_o <= 1'b0;
    end else begin
      scan_o      <= adv;
      dcd_relay_o <= relay;
      if (relay) begin
        seen_ff     <= 1'b1;
        last_cnt_ff <= dcd_count_i;
      end
      if (modem_reset_i && !relay) force_ff <= 1'b1;
      else if (relay) force_ff <= 1'b0;
      next_channel_o <= tunnel_error_i && adv;
    end
  end

  // Host information report
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      info_send_o  <= 1'b0;
      info_upstream_channel_ident_o  <= 8'h00;
      info_owner_o <= 16'h0000;
    end else begin
      info_send_o <= upstream_channel_ident_known_i;
      if (upstream_channel_ident_known_i) begin
        info_upstream_channel_ident_o  <= upstream_channel_ident_i;
        info_owner_o <= owner_id_i;
      end
    end
  end

  a_query_tag_first: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    query_start_i && !q_busy |=> ##1 query_byte_o.data == TAG_MODE_QUERY[23:16]
    ) else $error("Query tag not sent");
  a_reset_legacy_mode: assert property (@(posedge ref_clk_i)
    $rose(rst_n) |-> mode_o == MODE_LEGACY) else $error("Not legacy after reset");
  a_legacy_tx_grant: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    tx_tune_i.valid && mode_o == MODE_LEGACY |=> tx_reply_o.status == STAT_GRANT
    ) else $error("Legacy tune not granted");
  a_busy_deny: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    tx_tune_i.valid && (mode_o == MODE_TUN2 || mode_o == MODE_ADV2)
    |=> tx_reply_o.valid && tx_reply_o.status == STAT_TX_BUSY) else $error("No busy deny");
  a_rx_deny_other: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    rx_tune_i.valid && is_tunnel(mode_o) |=> rx_reply_o.status == STAT_OTHER
    ) else $error("Forward tune not denied");
  a_oneway_tx_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (mode_o == MODE_TUN1 || mode_o == MODE_ADV1) ##1 $stable(mode_o)
    |-> !return_tx_en_o && !modem_tx_en_o) else $error("Transmitter on one-way");
  a_basic_no_relay: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    is_basic(mode_o) |=> !dcd_relay_o || !is_basic($past(mode_o))) else $error("Relay in basic");
  a_reserved_ignored: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    cb && st_ff == P_MODE && byte_ff == 3'd1 && !mode_ok |=> $stable(mode_o)
    ) else $error("Reserved mode applied");
endmodule

// File: tmf_top_bench.sv
// Self-checking bench for the tunnel mode and filter control block.
// Assumes the card model in tmf_card.sv and a 20 MHz clock.
`timescale 1ns/1ps
module tmf_top_bench;
  import tmf_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_n_i, query_start_i, flow_open_i, pkt_ready_o, stall;
  logic dcd_valid_i, modem_reset_i, dcd_relay_o, tunnel_error_i, next_channel_o;
  logic return_tx_en_o, modem_tx_en_o, fwd_rx_en_o, scan_o, channel_valid_o;
  logic upstream_channel_ident_known_i, info_send_o, fwd_ready_i;
  logic [7:0] mode_o, dcd_count_i, upstream_channel_ident_i, info_upstream_channel_ident_o, md, em;
  logic [15:0] owner_id_i, info_owner_o;
  logic [31:0] got;
  tmf_byte_t query_byte_o, card_msg_i, pkt_i, fwd_o;
  tmf_tune_t tx_tune_i, rx_tune_i, tx_setting_o;
  tmf_reply_t tx_reply_o, rx_reply_o;
  int n_errors = 0;
  int comparisons = 0;
  int n, full, i;
  localparam logic [47:0] MAC_A = 48'h0211_2233_4455;

  tmf_top tmf_top_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .query_start_i(query_start_i), .query_byte_o(query_byte_o), .card_msg_i(card_msg_i),
    .pkt_i(pkt_i), .flow_open_i(flow_open_i), .pkt_ready_o(pkt_ready_o), .fwd_o(fwd_o),
    .fwd_ready_i(fwd_ready_i), .tx_tune_i(tx_tune_i), .rx_tune_i(rx_tune_i),
    .tx_reply_o(tx_reply_o), .rx_reply_o(rx_reply_o), .tx_setting_o(tx_setting_o),
    .mode_o(mode_o), .return_tx_en_o(return_tx_en_o), .modem_tx_en_o(modem_tx_en_o),
    .fwd_rx_en_o(fwd_rx_en_o), .scan_o(scan_o), .dcd_count_i(dcd_count_i),
    .dcd_valid_i(dcd_valid_i), .modem_reset_i(modem_reset_i), .dcd_relay_o(dcd_relay_o),
    .tunnel_error_i(tunnel_error_i), .next_channel_o(next_channel_o),
    .channel_valid_o(channel_valid_o), .upstream_channel_ident_known_i(upstream_channel_ident_known_i), .upstream_channel_ident_i(upstream_channel_ident_i),
    .owner_id_i(owner_id_i), .info_send_o(info_send_o), .info_upstream_channel_ident_o(info_upstream_channel_ident_o),
    .info_owner_o(info_owner_o));
  tmf_card tmf_card_inst (.clk_i(ref_clk_i), .stall_i(stall), .fwd_i(fwd_o),
    .ready_o(fwd_ready_i), .msg_o(card_msg_i));

  always #25 ref_clk_i = ~ref_clk_i;

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One-cycle strobes: tx, rx, descriptor, error, upstream id, modem reset
  task automatic fire(input logic [5:0] s);
    @(negedge ref_clk_i);
    {modem_reset_i, upstream_channel_ident_known_i, tunnel_error_i, dcd_valid_i} = s[5:2];
    tx_tune_i.valid = s[0];
    rx_tune_i.valid = s[1];
    @(negedge ref_clk_i);
    {modem_reset_i, upstream_channel_ident_known_i, tunnel_error_i, dcd_valid_i} = '0;
    tx_tune_i.valid = 1'b0;
    rx_tune_i.valid = 1'b0;
  endtask
  // Sixteen-byte packet, destination first, held while refused
  task automatic send_pkt(input logic [47:0] mac);
    int k, j;
    for (k = 0; k < 16; k++) begin
      @(negedge ref_clk_i);
      pkt_i.valid = 1'b1;
      pkt_i.last = (k == 15);
      pkt_i.data = (k < 6) ? mac[47-8*k -: 8] : 8'(8'h10 + k);
      for (j = 0; j < 100 && pkt_ready_o !== 1'b1; j++) begin
        full++;
        @(negedge ref_clk_i);
      end
    end
    @(negedge ref_clk_i);
    pkt_i = '0;
  endtask

  initial begin
    #(50ns * 4000);
    n_errors++;
    close_out();
  end

  initial begin
    {query_start_i, flow_open_i, stall, dcd_valid_i, modem_reset_i} = '0;
    {tunnel_error_i, upstream_channel_ident_known_i, dcd_count_i, upstream_channel_ident_i, owner_id_i, got} = '0;
    pkt_i = '0;
    tx_tune_i = '{1'b0, 32'h1234_5678, 8'h03, 8'h2C};
    rx_tune_i = '{1'b0, 32'h0ABC_0000, 8'h01, 8'h00};
    reset_n_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i) reset_n_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    check(mode_o, MODE_LEGACY);
    check({return_tx_en_o, fwd_rx_en_o}, 2'h3);
    query_start_i = 1'b1;
    @(negedge ref_clk_i) query_start_i = 1'b0;
    n = 0;
    for (i = 0; i < 10; i++) begin
      @(negedge ref_clk_i);
      if (query_byte_o.valid === 1'b1) begin
        got = {got[23:0], query_byte_o.data};
        n++;
        if (n == 4) check(query_byte_o.last, 1'b1);
      end
    end
    check(got, {TAG_MODE_QUERY, QUERY_LEN});
    check(n, 4);
    // Every code, then a reserved one, then back to legacy
    for (i = 1; i <= 6; i++) begin
      md = 8'(i % 6);
      tmf_card_inst.send_select(md, MAC_A, 16'h0008, (md >= 8'h01 && md <= MODE_ADV1));
      repeat (3) @(negedge ref_clk_i);
      em = (md == 8'h05) ? MODE_ADV1 : md;
      check(mode_o, em);
      fire(6'h03);
      check({tx_reply_o.valid, rx_reply_o.valid}, 2'h3);
      check(tx_reply_o.status, em == 0 ? STAT_GRANT : em[0] ? STAT_TX_BUSY : STAT_OTHER);
      check(rx_reply_o.status, em == 0 ? STAT_GRANT : STAT_OTHER);
      check(scan_o, em >= 3);
      check(fwd_rx_en_o, em == 0);
      if (em == 2 || em == 4) check({return_tx_en_o, modem_tx_en_o}, 2'h0);
      if (em == 0) check(tx_setting_o.freq, 32'h1234_5678);
    end
    tmf_card_inst.send_select(MODE_ADV2, MAC_A, 16'h0008, 1'b1);
    repeat (3) @(negedge ref_clk_i);
    dcd_count_i = 8'h05;
    fire(6'h04);
    check(dcd_relay_o, 1'b1);
    fire(6'h04);
    check(dcd_relay_o, 1'b0);
    dcd_count_i = 8'h06;
    fire(6'h04);
    check(dcd_relay_o, 1'b1);
    fire(6'h24);
    check(dcd_relay_o, 1'b1);
    fire(6'h08);
    check(next_channel_o, 1'b1);
    upstream_channel_ident_i = 8'h2A;
    owner_id_i = 16'h0001;
    fire(6'h10);
    check({info_send_o, info_upstream_channel_ident_o, info_owner_o}, {1'b1, 8'h2A, 16'h0001});
    // Basic two-way tunnel: descriptors stay, only the listed address passes
    tmf_card_inst.send_select(MODE_TUN2, MAC_A, 16'h0006, 1'b1);
    flow_open_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    fire(6'h04);
    check(dcd_relay_o, 1'b0);
    full = 0;
    stall = 1'b1;
    send_pkt(MAC_A ^ 48'h1);
    fork
      send_pkt(MAC_A);
      begin
        repeat (30) @(negedge ref_clk_i);
        stall = 1'b0;
      end
    join
    repeat (20) @(negedge ref_clk_i);
    check(full != 0, 1'b1);
    check(tmf_card_inst.rx_q.size(), 10);
    for (i = 0; i < 10 && i < tmf_card_inst.rx_q.size(); i++)
      check(tmf_card_inst.rx_q[i], 8'(8'h16 + i));
    check(channel_valid_o, 1'b1);
    // Strip count zero: the whole packet goes through, destination included
    tmf_card_inst.send_select(MODE_TUN1, MAC_A, 16'h0000, 1'b1);
    repeat (3) @(negedge ref_clk_i);
    n = tmf_card_inst.rx_q.size();
    send_pkt(MAC_A);
    repeat (20) @(negedge ref_clk_i);
    check(tmf_card_inst.rx_q.size() - n, 16);
    check(tmf_card_inst.rx_q[n], MAC_A[47:40]);
    check(tmf_card_inst.rx_q[n + 5], MAC_A[7:0]);
    check(tmf_card_inst.rx_q[n + 15], 8'h1F);
    close_out();
  end
endmodule
